/* core/bfsc_defines.svh */
// Purpose: constants of the buck fault and sync configuration block
// Assumes: 20 MHz clock, APB register access
`ifndef BFSC_DEFINES_SVH
`define BFSC_DEFINES_SVH
// Timing
`define BFSC_CLK_NS        50
`define BFSC_MS_NS         1000000
`define BFSC_CLK_KHZ       16'h4e20
// Register byte addresses
`define BFSC_A_MODE        8'h00
`define BFSC_A_FREQ        8'h04
`define BFSC_A_VOUT        8'h08
`define BFSC_A_LIM_LAST    8'h28
`define BFSC_A_SCALE       8'h2c
`define BFSC_A_START       8'h30
`define BFSC_A_DELAY       8'h34
`define BFSC_A_OTLIM       8'h38
`define BFSC_A_STATUS      8'h3c
`define BFSC_A_MASK        8'h40
`define BFSC_A_STATE       8'h44
// Reset values
`define BFSC_R_START_MS    16'h0014
`define BFSC_R_DELAY_MS    16'h0014
`define BFSC_R_OTLIM       8'h7d
`define BFSC_R_VOUT        16'h0200
// Mode command codes
`define BFSC_CMD_ALONE     16'h0000
`define BFSC_CMD_MASTER    16'h0100
`define BFSC_CMD_SLV_IN    16'h0120
`define BFSC_CMD_SLV_OUT   16'h0121
// Frequency override step
`define BFSC_FREQ_STEP     11'h032
// Select pin codes for grounded and open
`define BFSC_VOLTAGE_SELECT_PIN_GND      4'h0
`define BFSC_VOLTAGE_SELECT_PIN_OPEN     4'hf
`define BFSC_RT_NONE       4'hf
// Target table, 1.953 mV units
`define BFSC_VOLTAGE_SELECT_PIN_TAB '{16'h0133, 16'h01cd, 16'h01e6, 16'h0200, 16'h021a, 16'h0266, \
   16'h0280, 16'h0300, 16'h039a, 16'h0433, 16'h0500, 16'h069a, 16'h0a00, 16'h1800}
// Frequency table, kHz
`define BFSC_RT_TAB '{11'h12c, 11'h190, 11'h1f4, 11'h226, 11'h258, 11'h28a, 11'h2bc, \
   11'h2ee, 11'h320, 11'h352, 11'h384, 11'h3b6, 11'h3e8, 11'h4e2, 11'h5dc}
// Limit percentages: uv trip, uv warn, ov trip, ov warn, margin dn/up, pg on/off
`define BFSC_LIM_PCT '{8'h50, 8'h5a, 8'h73, 8'h6e, 8'h5f, 8'h69, 8'h5a, 8'h55}
`define BFSC_PCT_DIV       24'h000064
// Loop scale thresholds
`define BFSC_SCALE_T1      16'h039a
`define BFSC_SCALE_T2      16'h0a00
// Status bits
`define BFSC_ST_TMO        0
`define BFSC_ST_OT         1
`define BFSC_ST_PB         2
`define BFSC_ST_LOST       3
`endif

/* core/bfsc_pkg.sv */
// Purpose: types of the buck fault and sync configuration block
// Assumes: nothing
// Notes: constants live in bfsc_defines.svh
package bfsc_pkg;
   typedef enum logic [2:0] {
      ST_LOCK   = 3'b000,
      ST_START  = 3'b001,
      ST_RUN    = 3'b010,
      ST_RETRY  = 3'b011,
      ST_OTHOLD = 3'b100
   } bfsc_state_t;
   typedef enum logic [1:0] {
      MODE_ALONE   = 2'b00,
      MODE_MASTER  = 2'b01,
      MODE_SLV_IN  = 2'b10,
      MODE_SLV_OUT = 2'b11
   } bfsc_mode_t;
endpackage

/* core/bfsc_sw_timer.sv */
// Purpose: switching period timer with sync reload
// Assumes: period of at least two cycles
// Notes: phase is high for the first half period
`timescale 1ns/1ps
`default_nettype none
module bfsc_sw_timer #(
   parameter int W = 16
)(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Control
   input  wire logic [W-1:0] period,
   input  wire logic         sync_load,
   input  wire logic         load_half,
   // Result
   output logic              phase
);
   logic [W-1:0] cnt_ff;
   logic [W-1:0] half;
   assign half = period >> 1;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_ff <= '0;
      end else if (sync_load) begin
         cnt_ff <= load_half ? half : '0;
      end else if (cnt_ff >= period - 1'b1) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end
   // Registered so the pin sees no decode glitches
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase <= 1'b0;
      end else begin
         phase <= (cnt_ff < half);
      end
   end
endmodule
`default_nettype wire

/* core/bfsc_top.sv */
// Purpose: fault supervision, set-point straps and sync mode of a buck stage
// Assumes: strap indices and sensed values come from an ADC, synchronous
// Notes: times are counted in millisecond ticks
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "bfsc_defines.svh"
module bfsc_top
   import bfsc_pkg::*;
#(
   parameter int MS_CYCLES = `BFSC_MS_NS / `BFSC_CLK_NS
)(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Interrupt
   output logic             irq,
   // Supervision inputs
   input  wire logic        supply_ok,
   input  wire logic [7:0]  die_temp,
   input  wire logic [15:0] vout_sense,
   input  wire logic [3:0]  voltage_select_pin_index,
   input  wire logic [3:0]  rt_index,
   // Power stage
   output logic             upper_switch,
   output logic             lower_switch,
   output logic             power_good,
   // Frequency and sync pin
   input  wire logic        freq_sync_pin_i,
   output logic             freq_sync_pin_o,
   output logic             freq_sync_pin_oe,
   // Active settings
   output logic      [15:0] vout_target,
   output logic      [10:0] fsw_khz,
   output logic      [1:0]  output_loop_scale
);
   localparam logic [15:0] VOLTAGE_SELECT_PIN_TAB [0:13] = `BFSC_VOLTAGE_SELECT_PIN_TAB;
   localparam logic [10:0] RT_TAB [0:14] = `BFSC_RT_TAB;
   localparam logic [7:0]  LIM_PCT [0:7] = `BFSC_LIM_PCT;

   // Index 0 target, then uv trip/warn, ov trip/warn, margins, pg on/off
   logic [15:0] lim_ff [0:8];
   logic [1:0]  scale_ff;
   logic [15:0] start_lim_ff;
   logic [15:0] delay_ff;
   logic [7:0]  ot_lim_ff;
   bfsc_mode_t  mode_ff;
   logic [4:0]  freq_ff;
   logic [3:0]  status_ff;
   logic [3:0]  mask_ff;
   logic        strapped_ff;
   logic [10:0] rt_khz_ff;
   bfsc_state_t state_ff;
   bfsc_state_t nxt_state;
   logic [19:0] ms_cnt_ff;
   logic [15:0] timer_ff;
   logic        prebias_ff;
   logic        sync_d_ff;
   logic [16:0] gap_ff;
   logic        present_ff;

   logic        wr_en;
   logic        setup;
   logic        addr_ok;
   logic        lim_hit;
   logic [3:0]  lim_idx;
   logic        mode_bad;
   bfsc_mode_t  wr_mode;
   logic [31:0] rd_data;
   logic        strap_now;
   logic [15:0] strap_tgt;
   logic        ms_tick;
   logic        temp_hot;
   logic        run_sw;
   logic        phase;
   logic [10:0] nxt_fsw;
   logic [15:0] period;
   logic        sync_rise;
   logic        slave;
   logic        present;
   logic [3:0]  events;

   function automatic logic [15:0] pct_of(input logic [15:0] v, input logic [7:0] p);
      logic [23:0] prod;
      prod = {8'h00, v} * {16'h0000, p};
      return 16'(prod / `BFSC_PCT_DIV);
   endfunction

   function automatic logic [15:0] mode_cmd(input bfsc_mode_t m);
      logic [15:0] c;
      c = `BFSC_CMD_ALONE;
      unique case (m)
         MODE_ALONE:   c = `BFSC_CMD_ALONE;
         MODE_MASTER:  c = `BFSC_CMD_MASTER;
         MODE_SLV_IN:  c = `BFSC_CMD_SLV_IN;
         MODE_SLV_OUT: c = `BFSC_CMD_SLV_OUT;
      endcase
      return c;
   endfunction

   // Bus decode
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite && !pslverr;
   assign lim_hit = (paddr >= `BFSC_A_VOUT) && (paddr <= `BFSC_A_LIM_LAST)
                    && (paddr[1:0] == 2'b00);
   assign lim_idx = 4'((paddr - `BFSC_A_VOUT) >> 2);
   assign pready = 1'b1;

   always_comb begin
      mode_bad = 1'b0;
      wr_mode = mode_ff;
      unique case (pwdata[15:0])
         `BFSC_CMD_ALONE:   wr_mode = MODE_ALONE;
         `BFSC_CMD_MASTER:  wr_mode = MODE_MASTER;
         `BFSC_CMD_SLV_IN:  wr_mode = MODE_SLV_IN;
         `BFSC_CMD_SLV_OUT: wr_mode = MODE_SLV_OUT;
         default:           mode_bad = 1'b1;
      endcase
   end

   // Read mux, sampled in the setup cycle
   always_comb begin
      addr_ok = 1'b1;
      rd_data = 32'h0000_0000;
      if (lim_hit) begin
         rd_data[15:0] = lim_ff[lim_idx];
      end else begin
         unique case (paddr)
            `BFSC_A_MODE:   rd_data[15:0] = mode_cmd(mode_ff);
            `BFSC_A_FREQ:   rd_data[4:0] = freq_ff;
            `BFSC_A_SCALE:  rd_data[1:0] = scale_ff;
            `BFSC_A_START:  rd_data[15:0] = start_lim_ff;
            `BFSC_A_DELAY:  rd_data[15:0] = delay_ff;
            `BFSC_A_OTLIM:  rd_data[7:0] = ot_lim_ff;
            `BFSC_A_STATUS: rd_data[3:0] = status_ff;
            `BFSC_A_MASK:   rd_data[3:0] = mask_ff;
            `BFSC_A_STATE:  rd_data = {5'h00, fsw_khz, 10'h000, power_good,
                                       present_ff, prebias_ff, state_ff};
            default:        addr_ok = 1'b0;
         endcase
      end
   end

   // Unmapped address or illegal mode code is refused
   assign pslverr = psel && penable
                    && (!addr_ok || (pwrite && paddr == `BFSC_A_MODE && mode_bad));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata <= rd_data;
      end
   end

   // straps caught once at first power-up
   assign strap_now = supply_ok && !strapped_ff;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         strapped_ff <= 1'b0;
         rt_khz_ff <= RT_TAB[0];
      end else if (strap_now) begin
         strapped_ff <= 1'b1;
         if (rt_index != `BFSC_RT_NONE) begin
            rt_khz_ff <= RT_TAB[rt_index];
         end
      end
   end

   // resistor target, else the bus value
   assign strap_tgt = (voltage_select_pin_index == `BFSC_VOLTAGE_SELECT_PIN_GND || voltage_select_pin_index == `BFSC_VOLTAGE_SELECT_PIN_OPEN)
                      ? lim_ff[0] : VOLTAGE_SELECT_PIN_TAB[4'(voltage_select_pin_index - 4'h1)];

   // Set-point and limit registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lim_ff[0] <= `BFSC_R_VOUT;
         for (int i = 1; i < 9; i++) begin
            lim_ff[i] <= 16'h0000;
         end
         scale_ff <= 2'h0;
      end else begin
         if (strap_now) begin
            lim_ff[0] <= strap_tgt;
            for (int i = 0; i < 8; i++) begin
               lim_ff[i+1] <= pct_of(strap_tgt, LIM_PCT[i]);
            end
            if (strap_tgt <= `BFSC_SCALE_T1) begin
               scale_ff <= 2'h0;
            end else if (strap_tgt <= `BFSC_SCALE_T2) begin
               scale_ff <= 2'h1;
            end else begin
               scale_ff <= 2'h2;
            end
         end
         // each value writable on its own
         if (wr_en && lim_hit) begin
            lim_ff[lim_idx] <= pwdata[15:0];
         end
         if (wr_en && paddr == `BFSC_A_SCALE) begin
            scale_ff <= pwdata[1:0];
         end
      end
   end

   // Time, mode and frequency settings
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         start_lim_ff <= `BFSC_R_START_MS;
         delay_ff <= `BFSC_R_DELAY_MS;
         ot_lim_ff <= `BFSC_R_OTLIM;
         mode_ff <= MODE_MASTER;
         freq_ff <= 5'h00;
         mask_ff <= 4'h0;
      end else if (wr_en) begin
         unique case (paddr)
            `BFSC_A_START: start_lim_ff <= pwdata[15:0];
            `BFSC_A_DELAY: delay_ff <= pwdata[15:0];
            `BFSC_A_OTLIM: ot_lim_ff <= pwdata[7:0];
            `BFSC_A_MODE:  mode_ff <= wr_mode;
            `BFSC_A_FREQ:  freq_ff <= pwdata[4:0];
            `BFSC_A_MASK:  mask_ff <= pwdata[3:0];
            default: ;
         endcase
      end
   end

   // Millisecond tick
   assign ms_tick = (ms_cnt_ff == 20'(MS_CYCLES - 1));
   always_ff @(posedge clk) begin
      if (!rst_n || ms_tick) begin
         ms_cnt_ff <= 20'h00000;
      end else begin
         ms_cnt_ff <= ms_cnt_ff + 20'h00001;
      end
   end

   assign temp_hot = die_temp > ot_lim_ff;

   // Supervision sequence
   always_comb begin
      nxt_state = state_ff;
      if (!supply_ok) begin
         nxt_state = ST_LOCK;
      // overtemp shuts down from any active state
      end else if (temp_hot && state_ff != ST_OTHOLD) begin
         nxt_state = ST_OTHOLD;
      end else begin
         unique case (state_ff)
            ST_LOCK:   nxt_state = ST_START;
            ST_START: begin
               if (!prebias_ff && vout_sense > lim_ff[1]) begin
                  nxt_state = ST_RUN;
               end else if (ms_tick && (17'(timer_ff) + 17'h1 >= 17'(start_lim_ff))) begin
                  nxt_state = ST_RETRY;
               end
            end
            ST_RUN:    nxt_state = ST_RUN;
            // wait the delay then try again
            ST_RETRY: begin
               if (ms_tick && (17'(timer_ff) + 17'h1 >= 17'(delay_ff))) begin
                  nxt_state = ST_START;
               end
            end
            ST_OTHOLD: begin
               if (!temp_hot) begin
                  nxt_state = ST_START;
               end
            end
            default:   nxt_state = ST_LOCK;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_ff <= ST_LOCK;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // timer cleared on every state entry
   always_ff @(posedge clk) begin
      if (!rst_n || nxt_state != state_ff) begin
         timer_ff <= 16'h0000;
      end else if (ms_tick) begin
         timer_ff <= timer_ff + 16'h0001;
      end
   end

   // pre-bias caught on entry, released once output sags
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prebias_ff <= 1'b0;
      end else if (nxt_state == ST_START && state_ff != ST_START) begin
         prebias_ff <= vout_sense > lim_ff[0];
      end else if (state_ff != ST_START || vout_sense <= lim_ff[0]) begin
         prebias_ff <= 1'b0;
      end
   end

   // Power good with hysteresis
   always_ff @(posedge clk) begin
      if (!rst_n || state_ff != ST_RUN) begin
         power_good <= 1'b0;
      end else if (vout_sense >= lim_ff[7]) begin
         power_good <= 1'b1;
      end else if (vout_sense < lim_ff[8]) begin
         power_good <= 1'b0;
      end
   end

   // bus override wins over the resistor
   always_comb begin
      nxt_fsw = rt_khz_ff;
      if (freq_ff != 5'h00) begin
         nxt_fsw = 11'({6'h00, freq_ff} * `BFSC_FREQ_STEP);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fsw_khz <= RT_TAB[0];
      end else begin
         fsw_khz <= nxt_fsw;
      end
   end

   // Divider is slow but fsw only moves on a bus write or when the straps are caught
   assign period = `BFSC_CLK_KHZ / {5'h00, fsw_khz};

   // External clock edge and presence
   assign slave = (mode_ff == MODE_SLV_IN) || (mode_ff == MODE_SLV_OUT);
   assign sync_rise = freq_sync_pin_i && !sync_d_ff;
   assign present = gap_ff < {period, 1'b0};
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync_d_ff <= 1'b0;
         gap_ff <= 17'h1ffff;
         present_ff <= 1'b0;
      end else begin
         sync_d_ff <= freq_sync_pin_i;
         present_ff <= slave && present;
         if (sync_rise) begin
            gap_ff <= 17'h00000;
         end else if (gap_ff != 17'h1ffff) begin
            gap_ff <= gap_ff + 17'h00001;
         end
      end
   end

   // slave realigns on each edge, at half period in slave-out mode and at zero in slave-in mode
   bfsc_sw_timer #(
      .W (16)
   ) u_timer (
      .clk       (clk),
      .rst_n     (rst_n),
      .period    (period),
      .sync_load (slave && sync_rise),
      .load_half (mode_ff == MODE_SLV_OUT),
      .phase     (phase)
   );

   // switches off outside start and run, or pre-biased
   assign run_sw = (state_ff == ST_START && !prebias_ff) || state_ff == ST_RUN;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         upper_switch <= 1'b0;
         lower_switch <= 1'b0;
      end else begin
         upper_switch <= run_sw && phase;
         lower_switch <= run_sw && !phase;
      end
   end

   // master drives once the straps are caught and while supply is ok; other modes release the pin
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         freq_sync_pin_o <= 1'b0;
         freq_sync_pin_oe <= 1'b0;
      end else begin
         freq_sync_pin_o <= phase;
         freq_sync_pin_oe <= mode_ff == MODE_MASTER && strapped_ff && supply_ok;
      end
   end

   // Sticky events; a set beats a same-cycle clear
   assign events[`BFSC_ST_TMO] = state_ff == ST_START && nxt_state == ST_RETRY;
   assign events[`BFSC_ST_OT] = nxt_state == ST_OTHOLD && state_ff != ST_OTHOLD;
   assign events[`BFSC_ST_PB] = nxt_state == ST_START && state_ff != ST_START
                                && vout_sense > lim_ff[0];
   assign events[`BFSC_ST_LOST] = present_ff && slave && !present;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_ff <= 4'h0;
      end else if (wr_en && paddr == `BFSC_A_STATUS) begin
         status_ff <= (status_ff & ~pwdata[3:0]) | events;
      end else begin
         status_ff <= status_ff | events;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_ff & mask_ff);
      end
   end

   assign vout_target = lim_ff[0];
   assign output_loop_scale = scale_ff;
endmodule
`default_nettype wire

/* testbench/bfsc_checker.sv */
// Purpose: port checks of bfsc_top
// Assumes: overtemp limit never set to 255
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module bfsc_checker #(
   parameter int MS_CYCLES = 20
)(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Bus
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pready,
   input  wire logic        pslverr,
   // Supervision
   input  wire logic        supply_ok,
   input  wire logic [7:0]  die_temp,
   input  wire logic [15:0] vout_sense,
   // Outputs
   input  wire logic        upper_switch,
   input  wire logic        lower_switch,
   input  wire logic        power_good,
   input  wire logic [15:0] vout_target,
   input  wire logic [10:0] fsw_khz,
   input  wire logic [1:0]  output_loop_scale
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   lock_off_a: assert property (!supply_ok ##1 !supply_ok |=> !upper_switch && !lower_switch)
      else $error("switching while supply locked out");
   hot_off_a: assert property (die_temp == 8'hff ##1 die_temp == 8'hff |=>
      !upper_switch && !lower_switch) else $error("switching while overheated");
   no_overlap_a: assert property (!(upper_switch && lower_switch))
      else $error("both switches on");
   zero_wait_a: assert property (psel && penable |-> pready)
      else $error("access phase stalled");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   pg_level_a: assert property ($rose(power_good) |->
      {16'h0, vout_sense} * 32'h64 + 32'h63 >= {16'h0, vout_target} * 32'h5a)
      else $error("power good below its on level");
   freq_step_a: assert property (fsw_khz % 11'h032 == 11'h000)
      else $error("frequency off the step grid");
   scale_map_a: assert property (output_loop_scale == 2'h1 |-> vout_target > 16'h039a)
      else $error("loop scale does not match target");
endmodule
`default_nettype wire

/* testbench/bfsc_plant.sv */
// Purpose: power stage filter and sync pin partner
// Assumes: no load, so sense never droops by itself
// Notes: cap clamps sense; force_en pins it at cap
`timescale 1ns/1ps
`default_nettype none
module bfsc_plant #(
   parameter logic [15:0] STEP     = 16'h0040,
   parameter int          EXT_HALF = 20
)(
   // Clock
   input  wire logic        clk,
   // Power stage and pin drive
   input  wire logic        upper_switch,
   input  wire logic        pin_o,
   input  wire logic        pin_oe,
   // Scenario control
   input  wire logic [15:0] cap,
   input  wire logic        force_en,
   input  wire logic        ext_en,
   // Observed
   output logic      [15:0] vout_sense,
   output logic             pin_level
);
   logic [16:0] nxt_sense;
   logic [15:0] sense_ff = 16'h0000;
   logic        ext_ff   = 1'b0;
   int          cnt_ff   = 0;
   assign nxt_sense  = {1'b0, sense_ff} + (upper_switch ? {1'b0, STEP} : 17'h00000);
   assign vout_sense = sense_ff;
   always_ff @(posedge clk) begin
      sense_ff <= (force_en || nxt_sense > {1'b0, cap}) ? cap : nxt_sense[15:0];
   end
   // external clock stands still when off
   always_ff @(posedge clk) begin
      if (!ext_en) begin
         cnt_ff <= 0;
         ext_ff <= 1'b0;
      end else if (cnt_ff == EXT_HALF - 1) begin
         cnt_ff <= 0;
         ext_ff <= ~ext_ff;
      end else begin
         cnt_ff <= cnt_ff + 1;
      end
   end
   // released pin sits low on its resistor
   assign pin_level = pin_oe ? pin_o : (ext_en & ext_ff);
endmodule
`default_nettype wire

/* testbench/test_bfsc_top.sv */
// Purpose: self-checking bench of bfsc_top
// Assumes: MS_CYCLES of 20, so 1 ms is 20 cycles
// Notes: plant model stands in for the power stage
`timescale 1ns/1ps
`default_nettype none
module test_bfsc_top;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr, die_temp;
   logic [31:0] pwdata, prdata;
   logic        supply_ok, upper_switch, lower_switch, power_good;
   logic [15:0] vout_sense, vout_target, cap;
   logic [3:0]  voltage_select_pin_index, rt_index;
   logic        pin_level, pin_o, pin_oe, force_en, ext_en;
   logic [10:0] fsw_khz;
   logic [1:0]  output_loop_scale;
   int          miscompares, samples_checked, n, i;
   bfsc_top #(.MS_CYCLES(20)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .supply_ok(supply_ok),
      .die_temp(die_temp), .vout_sense(vout_sense), .voltage_select_pin_index(voltage_select_pin_index),
      .rt_index(rt_index), .upper_switch(upper_switch), .lower_switch(lower_switch),
      .power_good(power_good), .freq_sync_pin_i(pin_level), .freq_sync_pin_o(pin_o),
      .freq_sync_pin_oe(pin_oe), .vout_target(vout_target), .fsw_khz(fsw_khz),
      .output_loop_scale(output_loop_scale));
   bfsc_plant plant_u (.clk(clk), .upper_switch(upper_switch), .pin_o(pin_o),
      .pin_oe(pin_oe), .cap(cap), .force_en(force_en), .ext_en(ext_en),
      .vout_sense(vout_sense), .pin_level(pin_level));
   always #25 clk = ~clk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("FAIL t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // One APB transfer; reads compare masked data
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, m, x,
                       input logic e);
      logic [31:0] r;
      logic        s;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      s = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (!w) chk(r & m, x);
      chk(s, e);
   endtask
   task automatic run_wait;
      for (n = 0; n < 400 && power_good !== 1'b1; n++) @(posedge clk);
      chk(power_good, 1'b1);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_defaults;
      xfer('0, 8'h00, '0, '1, 32'h100, '0);
      xfer('0, 8'h30, '0, '1, 32'h14, '0);
      xfer('0, 8'h34, '0, '1, 32'h14, '0);
      xfer('0, 8'h38, '0, '1, 32'h7d, '0);
      xfer('1, 8'h48, 32'h5, '1, '0, '1);
      xfer('0, 8'h48, '0, '1, '0, '1);
   endtask
   task automatic t_straps;
      logic [31:0] pct [8] = '{32'h50, 32'h5a, 32'h73, 32'h6e, 32'h5f, 32'h69, 32'h5a, 32'h55};
      supply_ok <= 1'b1;
      repeat (3) @(posedge clk);
      chk(vout_target, 32'ha00);
      chk(output_loop_scale, 32'h1);
      chk(fsw_khz, 32'h1f4);
      for (i = 0; i < 8; i++) xfer('0, 8'(12 + 4 * i), '0, '1, 32'ha00 * pct[i] / 32'h64, '0);
      run_wait;
   endtask
   task automatic t_modes;
      logic [31:0] code [4] = '{32'h0, 32'h100, 32'h120, 32'h121};
      for (i = 0; i < 4; i++) begin
         xfer('1, 8'h00, code[i], '1, '0, '0);
         xfer('0, 8'h00, '0, '1, code[i], '0);
         chk(pin_oe, i == 1);
      end
      xfer('1, 8'h00, 32'h122, '1, '0, '1);
      xfer('0, 8'h00, '0, '1, 32'h121, '0);
      xfer('1, 8'h00, 32'h100, '1, '0, '0);
      @(posedge clk);
      n = 0;
      repeat (160) begin
         @(posedge clk);
         n += pin_level;
      end
      chk(n, 32'h50);
      xfer('1, 8'h04, 32'h5, '1, '0, '0);
      repeat (2) @(posedge clk);
      chk(fsw_khz, 32'hfa);
      xfer('1, 8'h04, '0, '1, '0, '0);
      repeat (2) @(posedge clk);
      chk(fsw_khz, 32'h1f4);
   endtask
   task automatic t_timeout;
      supply_ok <= 1'b0;
      cap       <= 16'h0700;
      force_en  <= 1'b1;
      xfer('1, 8'h30, 32'h2, '1, '0, '0);
      xfer('1, 8'h34, 32'h2, '1, '0, '0);
      xfer('1, 8'h3c, 32'hf, '1, '0, '0);
      xfer('1, 8'h40, 32'h1, '1, '0, '0);
      force_en  <= 1'b0;
      supply_ok <= 1'b1;
      repeat (15) @(posedge clk);
      chk(irq, 1'b0);
      for (i = 0; i < 80 && irq !== 1'b1; i++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk({irq, upper_switch, lower_switch}, 32'h4);
      xfer('1, 8'h3c, 32'h1, '1, '0, '0);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      for (i = 0; i < 120 && irq !== 1'b1; i++) @(posedge clk);
      chk(irq, 1'b1);
      xfer('1, 8'h40, '0, '1, '0, '0);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      cap <= 16'hffff;
      run_wait;
   endtask
   task automatic t_prebias;
      supply_ok <= 1'b0;
      cap       <= 16'h0b00;
      force_en  <= 1'b1;
      xfer('1, 8'h3c, 32'hf, '1, '0, '0);
      supply_ok <= 1'b1;
      n = 0;
      repeat (15) begin
         @(posedge clk);
         n += upper_switch + lower_switch;
      end
      chk(n, '0);
      xfer('0, 8'h3c, '0, 32'h4, 32'h4, '0);
      cap <= 16'h0000;
      repeat (2) @(posedge clk);
      cap      <= 16'hffff;
      force_en <= 1'b0;
      run_wait;
   endtask
   task automatic t_hot_slave;
      xfer('1, 8'h3c, 32'hf, '1, '0, '0);
      die_temp <= 8'hff;
      cap      <= 16'h0900;
      repeat (5) @(posedge clk);
      chk({upper_switch, lower_switch}, '0);
      xfer('0, 8'h3c, '0, 32'h2, 32'h2, '0);
      die_temp <= 8'h19;
      run_wait;
      cap <= 16'hffff;
      xfer('1, 8'h00, 32'h120, '1, '0, '0);
      ext_en <= 1'b1;
      repeat (200) @(posedge clk);
      xfer('0, 8'h44, '0, 32'h10, 32'h10, '0);
      chk(pin_oe, 1'b0);
      n = 0;
      repeat (80) begin
         @(posedge clk);
         n += (upper_switch == pin_level);
      end
      chk(n > 60, 1'b1);
      xfer('1, 8'h00, 32'h121, '1, '0, '0);
      repeat (40) @(posedge clk);
      n = 0;
      repeat (80) begin
         @(posedge clk);
         n += (upper_switch == pin_level);
      end
      chk(n < 20, 1'b1);
      ext_en <= 1'b0;
      repeat (200) @(posedge clk);
      xfer('0, 8'h44, '0, 32'h10, '0, '0);
      xfer('0, 8'h3c, '0, 32'h8, 32'h8, '0);
   endtask
   initial begin
      {clk, rst_n, psel, penable, pwrite, supply_ok, force_en, ext_en} = '0;
      {paddr, pwdata} = '0;
      die_temp   = 8'h19;
      voltage_select_pin_index = 4'hd;
      rt_index   = 4'h2;
      cap        = 16'hffff;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_defaults;
      t_straps;
      t_modes;
      t_timeout;
      t_prebias;
      t_hot_slave;
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      $display("FAIL t=%0t watchdog expired", $time);
      end_sim;
   end
endmodule
bind bfsc_top bfsc_checker #(.MS_CYCLES(MS_CYCLES)) chk_u (.clk(clk), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .supply_ok(supply_ok), .die_temp(die_temp), .vout_sense(vout_sense),
   .upper_switch(upper_switch), .lower_switch(lower_switch), .power_good(power_good),
   .vout_target(vout_target), .fsw_khz(fsw_khz), .output_loop_scale(output_loop_scale));
`default_nettype wire
